// ### hdl/pcs_rmii_cfg_map.vh
// Purpose: offsets, field positions, reset values and timing for the
//          coding-layer and reduced-MII configuration registers
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   printed offsets are register indices; byte address is 4x index
`ifndef PCS_RMII_CFG_MAP_VH
`define PCS_RMII_CFG_MAP_VH

// register indices as printed, and the byte addresses derived from them
`define CODING_LAYER_INDEX      8'h16
`define REDUCED_MII_INDEX       8'h17
`define CODING_LAYER_ADDR       10'h058
`define REDUCED_MII_ADDR        10'h05C

// coding_layer_config_status fields
`define CL_FORCE_GOOD_LINK_BIT  5
`define CL_RESERVED_RO_BIT      4
`define CL_FAR_FAULT_EN_BIT     3
`define CL_NRZI_SKIP_BIT        2
`define CL_SCRAMBLER_SKIP_BIT   1
`define CL_DESCRAMBLER_SKIP_BIT 0
`define CL_WRITE_MASK           16'h002F

// reduced_mii_and_bypass_control fields
`define RM_RESERVED_HI_BIT      15
`define RM_MASTER_BIT           14
`define RM_REALIGN_DISABLE_BIT  13
`define RM_RESERVED_LO_MSB      12
`define RM_RESERVED_LO_LSB      9
`define RM_WRITE_MASK           16'hFE00

// fixed reset values (strap-fed fields are loaded after release)
`define CL_RESET_VALUE          16'h0000
`define RM_RESET_VALUE          16'h0000

// AXI responses
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

// strap capture: cycles after reset release before the straps are taken,
// covering the two synchroniser stages
`define STRAP_SETTLE_CYCLES     2'h3

`endif

// ### hdl/pcs_and_rmii_config_regs.v
// Purpose: configuration bits of the 100 Mb/s coding layer and the upper
//          reduced-MII mode register, reached over AXI4-Lite
// Assumes: one clock aclk (200 MHz), synchronous active-low aresetn;
//          strap and MAC-side pins are asynchronous and are synchronised
// Notes:   register bus is stalled until the straps are captured after reset
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pcs_rmii_cfg_map.vh"

// Summary of operation
// - force good link: bit OR MAC input
// - bit 4 ignores writes, reads zero
// - far fault enable; fiber strap presets one
// - NRZI bypass bit, resets to zero
// - scrambler skip; fiber strap presets one
// - descrambler skip; fiber strap presets one
// - mode register holds interface selection controls
// - master bit: derive own reference clock
// - master zero means slave; strap sets reset
// - realign disable zero: realign each packet start
// - disable set: no realign, whole-symbol idles
module pcs_and_rmii_config_regs
(
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // straps and MAC-side pins (asynchronous)
  input  wire        fiber_mode_strap,
  input  wire        rmii_master_strap,
  input  wire        mac_side_link_force_input,
  input  wire        tx_enable_pin,
  // controls to the datapath
  output reg         link_good_force,
  output reg         far_fault_indication_enable,
  output reg         nrzi_skip,
  output reg         tx_scrambler_skip,
  output reg         rx_descrambler_skip,
  output reg         rmii_master_mode,
  output reg         ref_clock_divide_enable,
  output reg         tx_latency_realign_disable,
  output reg         tx_phase_realign,
  output reg         idle_whole_symbols
);

  // stored register contents
  reg  [15:0] coding_layer_config_status;      // coding-layer config
  reg  [15:0] reduced_mii_and_bypass_control;  // reduced-MII mode bits

  // synchroniser chains: stage one feeds stage two only
  reg  [3:0]  sync_stage1;                     // first flops
  reg  [3:0]  sync_stage2;                     // second flops, safe to use
  reg         tx_enable_last;                  // edge detect on stage two

  // strap capture sequencing
  reg  [1:0]  strap_wait;                      // cycles since release
  reg         straps_loaded;                   // bus open once set

  // write and read side bookkeeping
  wire        write_take;                      // both channels hand over
  wire        read_take;                       // read address handed over
  wire [9:0]  write_word;                      // word-aligned write address
  wire [9:0]  read_word;                       // word-aligned read address

  // byte-lane merge: only lanes with strobe high change, only masked bits
  function [15:0] merge_write;
    input [15:0] old_value;
    input [15:0] new_value;
    input [1:0]  strobes;
    input [15:0] write_mask;
    reg   [15:0] lane_mask;
    begin
      lane_mask   = {{8{strobes[1]}}, {8{strobes[0]}}} & write_mask;
      merge_write = (old_value & ~lane_mask) | (new_value & lane_mask);
    end
  endfunction

  // address decode shared by both channels
  function is_mapped;
    input [9:0] word_addr;
    begin
      is_mapped = (word_addr == `CODING_LAYER_ADDR) ||
                  (word_addr == `REDUCED_MII_ADDR);
    end
  endfunction

  // the readies only rise while both valids wait, so one edge takes both halves
  assign write_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign read_take  = s_axi_arvalid & s_axi_arready;
  assign write_word = {s_axi_awaddr[9:2], 2'h0};
  assign read_word  = {s_axi_araddr[9:2], 2'h0};

  // two-flop synchronisers for straps and MAC-side pins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_stage1 <= 4'h0;
      sync_stage2 <= 4'h0;
    end
    else
    begin
      sync_stage1 <= {tx_enable_pin, mac_side_link_force_input,
                      rmii_master_strap, fiber_mode_strap};
      sync_stage2 <= sync_stage1;
    end
  end

  // strap capture waits for the synchronisers to fill after release
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_wait    <= 2'h0;
      straps_loaded <= 1'b0;
    end
    else if (!straps_loaded)
    begin
      if (strap_wait == `STRAP_SETTLE_CYCLES)
        straps_loaded <= 1'b1;               // capture happens this edge
      else
        strap_wait <= strap_wait + 2'h1;
    end
  end

  // write handshake: take address and data together, one write at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_RESP_OKAY;
    end
    else if (write_take)
    begin
      // readies drop after one cycle; the response follows both channels
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= is_mapped(write_word) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;                // response taken
      // open the readies only when both halves wait and no response is due
      if (straps_loaded && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
          !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register storage: fixed reset, strap capture, then software writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      coding_layer_config_status     <= `CL_RESET_VALUE;
      reduced_mii_and_bypass_control <= `RM_RESET_VALUE;
    end
    else if (!straps_loaded)
    begin
      if (strap_wait == `STRAP_SETTLE_CYCLES)
      begin
        // fiber mode runs unscrambled with far-end fault indication on
        coding_layer_config_status[`CL_FAR_FAULT_EN_BIT]     <= sync_stage2[0];
        coding_layer_config_status[`CL_SCRAMBLER_SKIP_BIT]   <= sync_stage2[0];
        coding_layer_config_status[`CL_DESCRAMBLER_SKIP_BIT] <= sync_stage2[0];
        reduced_mii_and_bypass_control[`RM_MASTER_BIT]       <= sync_stage2[1];
      end
    end
    else if (write_take)
    begin
      // bit 4 is outside the write mask so writes never reach it
      if (write_word == `CODING_LAYER_ADDR)
        coding_layer_config_status <= merge_write(coding_layer_config_status,
                                                  s_axi_wdata[15:0], s_axi_wstrb[1:0],
                                                  `CL_WRITE_MASK);
      // reserved bits stay read-write; software is expected to keep them 0
      if (write_word == `REDUCED_MII_ADDR)
        reduced_mii_and_bypass_control <= merge_write(reduced_mii_and_bypass_control,
                                                      s_axi_wdata[15:0], s_axi_wstrb[1:0],
                                                      `RM_WRITE_MASK);
    end
  end

  // read handshake: address taken, data one cycle later, held until taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end
    else if (read_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= is_mapped(read_word) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      // upper bits and unmapped words read as zero
      if (read_word == `CODING_LAYER_ADDR)
        s_axi_rdata <= {16'h0000, coding_layer_config_status & `CL_WRITE_MASK};
      else if (read_word == `REDUCED_MII_ADDR)
        s_axi_rdata <= {16'h0000, reduced_mii_and_bypass_control & `RM_WRITE_MASK};
      else
        s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;                // data taken
      if (straps_loaded && s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
    end
  end

  // datapath controls, all registered so outputs come from flops
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_good_force             <= 1'b0;
      far_fault_indication_enable <= 1'b0;
      nrzi_skip                   <= 1'b0;
      tx_scrambler_skip           <= 1'b0;
      rx_descrambler_skip         <= 1'b0;
      rmii_master_mode            <= 1'b0;
      ref_clock_divide_enable     <= 1'b0;
      tx_latency_realign_disable  <= 1'b0;
      idle_whole_symbols          <= 1'b0;
    end
    else
    begin
      // either software or the MAC can hold the 100 Mb/s link up
      link_good_force <= coding_layer_config_status[`CL_FORCE_GOOD_LINK_BIT] |
                         sync_stage2[2];
      far_fault_indication_enable <= coding_layer_config_status[`CL_FAR_FAULT_EN_BIT];
      nrzi_skip           <= coding_layer_config_status[`CL_NRZI_SKIP_BIT];
      tx_scrambler_skip   <= coding_layer_config_status[`CL_SCRAMBLER_SKIP_BIT];
      rx_descrambler_skip <= coding_layer_config_status[`CL_DESCRAMBLER_SKIP_BIT];
      // master: 25 MHz in, divider/mux produces the 50 MHz reference the MAC
      // also uses; slave: 50 MHz taken straight in. changing this live can
      // glitch the shared clock, hence it is normally left as strapped
      rmii_master_mode        <= reduced_mii_and_bypass_control[`RM_MASTER_BIT];
      ref_clock_divide_enable <= reduced_mii_and_bypass_control[`RM_MASTER_BIT];
      // raw disable bit exported so the transmitter can pick its idle handling
      tx_latency_realign_disable <= reduced_mii_and_bypass_control[`RM_REALIGN_DISABLE_BIT];
      // without realignment idles go out only in whole symbols
      idle_whole_symbols <= reduced_mii_and_bypass_control[`RM_REALIGN_DISABLE_BIT];
    end
  end

  // packet-start realignment pulse on the rising edge of transmit enable
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_enable_last   <= 1'b0;
      tx_phase_realign <= 1'b0;
    end
    else
    begin
      tx_enable_last   <= sync_stage2[3];
      // suppressed while realignment is disabled
      tx_phase_realign <= sync_stage2[3] & ~tx_enable_last &
                          ~reduced_mii_and_bypass_control[`RM_REALIGN_DISABLE_BIT];
    end
  end

endmodule

// ### verif/mac_side_model.sv
// Purpose: MAC-side partner driving link force and transmit enable
// Assumes: commands from the bench, one clock shared with the block
// Notes:   registered so pins never move on the sampling edge
`timescale 1ns/1ps
module mac_side_model
(
  input  wire aclk,
  input  wire link_force_cmd,
  input  wire tx_start_cmd,
  output reg  mac_side_link_force_input,
  output reg  tx_enable_pin
);
  initial mac_side_link_force_input = 1'b0;
  initial tx_enable_pin = 1'b0;
  // mac runs its side off the shared reference clock
  always @(posedge aclk)
  begin
    mac_side_link_force_input <= link_force_cmd;
    tx_enable_pin             <= tx_start_cmd;
  end
endmodule

// ### verif/pcs_rmii_cfg_monitor.sv
// Purpose: port-level checks for the configuration register block
// Assumes: one clock, synchronous active-low reset
// Notes:   pin-driven outputs lag their pins by three cycles
`timescale 1ns/1ps
module pcs_rmii_cfg_monitor
(
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        mac_side_link_force_input,
  input wire        link_good_force,
  input wire        rmii_master_mode,
  input wire        ref_clock_divide_enable,
  input wire        tx_latency_realign_disable,
  input wire        tx_phase_realign,
  input wire        idle_whole_symbols
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both channels of a write are taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp;  s_wr_taken |=> s_axi_bvalid; endproperty
  property p_aw_w;     s_axi_awready |-> s_axi_wready; endproperty
  property p_b_hold;   s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rd_resp;  s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rsv_zero; s_axi_rvalid |-> !s_axi_rdata[4]; endproperty
  property p_force;    mac_side_link_force_input [*4] |-> link_good_force; endproperty
  property p_master;   ref_clock_divide_enable == rmii_master_mode; endproperty
  property p_realign;
    tx_phase_realign |-> !tx_latency_realign_disable ##1 !tx_phase_realign;
  endproperty
  property p_idle;     idle_whole_symbols == tx_latency_realign_disable; endproperty
  a_wr_resp:  assert property (p_wr_resp) else $error("no write response");
  a_aw_w:     assert property (p_aw_w) else $error("write readies split");
  a_b_hold:   assert property (p_b_hold) else $error("bvalid dropped early");
  a_rd_resp:  assert property (p_rd_resp) else $error("no read response");
  a_r_hold:   assert property (p_r_hold) else $error("read data not held");
  a_rsv_zero: assert property (p_rsv_zero) else $error("bit 4 read high");
  a_force:    assert property (p_force) else $error("link force missed");
  a_master:   assert property (p_master) else $error("clock select off");
  a_realign:  assert property (p_realign) else $error("bad realign");
  a_idle:     assert property (p_idle) else $error("idle mode off");
endmodule
bind pcs_and_rmii_config_regs pcs_rmii_cfg_monitor u_pcs_rmii_cfg_monitor
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mac_side_link_force_input(mac_side_link_force_input),
  .link_good_force(link_good_force), .rmii_master_mode(rmii_master_mode),
  .ref_clock_divide_enable(ref_clock_divide_enable),
  .tx_latency_realign_disable(tx_latency_realign_disable),
  .tx_phase_realign(tx_phase_realign), .idle_whole_symbols(idle_whole_symbols)
);

// ### verif/tb.sv
// Purpose: register and pin checks of the configuration block
// Assumes: AXI4-Lite master tasks, MAC partner model
// Notes:   bus waits are bounded so a stalled slave ends the run
`timescale 1ns/1ps
`include "pcs_rmii_cfg_map.vh"
module tb;
  reg aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  reg [31:0] awa = 0, wd = 0, ara = 0;
  reg [3:0] ws = 0;
  reg fib = 0, mst = 0, lf = 0, txs = 0;
  wire awr, wr, bv, arr, rv, mf, te, lgf, ffe, nz, scr, dsc, mm, rce, tld, tpr, iws;
  wire [1:0] br, rr;
  wire [31:0] rd;
  integer errors = 0, comparisons = 0, pulses = 0;
  localparam [31:0] CL = {22'h0, `CODING_LAYER_ADDR}, RM = {22'h0, `REDUCED_MII_ADDR};
  always #2.5 aclk = ~aclk;
  pcs_and_rmii_config_regs u_pcs_and_rmii_config_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .fiber_mode_strap(fib),
    .rmii_master_strap(mst), .mac_side_link_force_input(mf), .tx_enable_pin(te),
    .link_good_force(lgf), .far_fault_indication_enable(ffe), .nrzi_skip(nz),
    .tx_scrambler_skip(scr), .rx_descrambler_skip(dsc), .rmii_master_mode(mm),
    .ref_clock_divide_enable(rce), .tx_latency_realign_disable(tld),
    .tx_phase_realign(tpr), .idle_whole_symbols(iws));
  mac_side_model u_mac_side_model (.aclk(aclk), .link_force_cmd(lf), .tx_start_cmd(txs),
    .mac_side_link_force_input(mf), .tx_enable_pin(te));
  // count realign pulses the block gives over the whole run
  always @(posedge aclk) if (tpr === 1'b1) pulses <= pulses + 1;
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // write: hold each channel until taken, response once both are in
  task axw(input [31:0] a, input [15:0] d, input [3:0] s, input [1:0] r);
    integer n;
  begin
    n = 0;
    @(posedge aclk);
    awa <= a; wd <= {16'h0000, d}; ws <= s; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge aclk);
      if (awr && awv) awv <= 0;
      if (wr && wv) wv <= 0;
      n = n + 1;
    end while (!(bv && bry) && n < 50);
    bry <= 0;
    chk({bv, br}, {1'b1, r});
  end
  endtask
  task axr(input [31:0] a, input [31:0] d, input [1:0] r);
    integer n;
  begin
    n = 0;
    @(posedge aclk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge aclk);
      if (arr && arv) arv <= 0;
      n = n + 1;
    end while (!(rv && rry) && n < 50);
    rry <= 0;
    chk(rd, d);
    chk({rv, rr}, {1'b1, r});
  end
  endtask
  task rst(input f, input m);
  begin
    @(posedge aclk);
    fib <= f; mst <= m; aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
  end
  endtask
  task pkt;
  begin
    @(posedge aclk); txs <= 1;
    repeat (8) @(posedge aclk);
    txs <= 0;
    repeat (6) @(posedge aclk);
  end
  endtask
  task stop_test;
  begin
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #20000;
    errors = errors + 1;
    stop_test;
  end
  initial
  begin
    rst(1, 1);
    axr(CL, 32'h0000000B, `AXI_RESP_OKAY);
    axr(RM, 32'h00004000, `AXI_RESP_OKAY);
    chk({ffe, scr, dsc, mm, rce}, 5'h1F);
    axw(CL, 16'hFFFF, 4'h3, `AXI_RESP_OKAY);
    axr(CL, 32'h0000002F, `AXI_RESP_OKAY);
    chk({lgf, nz}, 2'h3);
    axw(CL, 16'h0000, 4'h3, `AXI_RESP_OKAY);
    axr(CL, 32'h00000000, `AXI_RESP_OKAY);
    chk({lgf, ffe, nz, scr, dsc}, 5'h00);
    axw(CL, 16'h0008, 4'h2, `AXI_RESP_OKAY);
    axr(CL, 32'h00000000, `AXI_RESP_OKAY);
    lf <= 1;
    repeat (6) @(posedge aclk);
    chk(lgf, 1);
    lf <= 0;
    repeat (6) @(posedge aclk);
    chk(lgf, 0);
    axw(RM, 16'h41FF, 4'h3, `AXI_RESP_OKAY);
    axr(RM, 32'h00004000, `AXI_RESP_OKAY);
    pkt;
    chk(pulses, 1);
    axw(RM, 16'h6000, 4'h3, `AXI_RESP_OKAY);
    pkt;
    chk(pulses, 1);
    chk({tld, iws}, 2'h3);
    axw(32'h60, 16'hFFFF, 4'h3, `AXI_RESP_SLVERR);
    axr(32'h60, 32'h0, `AXI_RESP_SLVERR);
    rst(0, 0);
    axr(CL, 32'h00000000, `AXI_RESP_OKAY);
    axr(RM, 32'h00000000, `AXI_RESP_OKAY);
    chk({mm, rce}, 2'h0);
    stop_test;
  end
endmodule
